/* File: hdl/supervisor_pkg.sv */
// Purpose: shared constants and types for the fault supervisor and share-mode control
// Assumes: 125 MHz reference clock, temperatures in whole degrees C, unsigned
// Notes: mode encoding 0 = current share, 1 = standalone
package supervisor_pkg;
	localparam int CLK_MHZ = 125;
	// status register
	localparam logic [7:0] STATUS_OFFSET = 8'h55;
	localparam int WARN_BIT = 5;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// mode command bytes
	localparam logic [7:0] CMD_BYTE1 = 8'h66;
	localparam logic [7:0] CMD_BYTE2 = 8'h99;
	localparam logic [7:0] CMD3_STANDALONE = 8'h10;
	localparam logic [7:0] CMD3_SHARE = 8'h00;
	localparam logic [2:0] CMD_LEN = 3'h4;
	localparam logic [2:0] REG_WR_LEN = 3'h2;
	localparam logic [1:0] COMMIT_REPEATS = 2'h3;
	localparam logic MODE_SHARE = 1'b0;
	// bus address
	localparam logic [4:0] ADDR_PREFIX = 5'h08;
	localparam int BUS_KHZ = 100;
	// timing
	localparam int SAMPLE_US = 200;
	localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
	localparam int IN_FAULT_US = 1000;
	localparam logic [2:0] IN_FAULT_SAMPLES = 3'((IN_FAULT_US + SAMPLE_US - 1) / SAMPLE_US);
	localparam int RETRY_S = 1;
	localparam int RETRY_CYCLES = RETRY_S * CLK_MHZ * 1000000;
	// temperature thresholds
	localparam logic [7:0] OT_ENTER_C = 8'h5f;
	localparam logic [7:0] OT_HYST_C = 8'h14;
	localparam logic [7:0] OT_LEAVE_C = 8'(OT_ENTER_C - OT_HYST_C);
	localparam logic [7:0] WARN_C = 8'h55;

	typedef enum logic [0:0] {FS_RUN, FS_TRIP} fault_state_type;
	typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_ACK_A, BS_WRX, BS_ACK_W, BS_TX, BS_ACK_R} bus_state_type;
endpackage

/* File: hdl/serial_link_if.sv */
// Purpose: byte-level link between the serial bus engine and the supervisor
// Assumes: one clock domain
// Notes: pulses last one cycle
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
	logic [6:0] own_addr;
	logic       enable;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic       rx_valid;
	logic       start_seen;
	logic       stop_seen;
	modport engine (input own_addr, input enable, input tx_byte,
		output rx_byte, output rx_valid, output start_seen, output stop_seen);
	modport supervisor (output own_addr, output enable, output tx_byte,
		input rx_byte, input rx_valid, input start_seen, input stop_seen);
endinterface
`default_nettype wire

/* File: hdl/serial_bus_engine.sv */
// Purpose: serial bus slave byte engine, address match, ack, byte receive and transmit
// Assumes: scl and sda already synchronous; clock far faster than the bus
// Notes: sda is open drain, sda_oe_n_out low while pulling low
`timescale 1ns/1ps
`default_nettype none
module serial_bus_engine (
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// bus pins
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	output logic                      sda_oe_n_out,
	// supervisor side
	serial_link_if.engine             link
);
	supervisor_pkg::bus_state_type st_q;
	logic       scl_q, sda_q, done_q, drive_q;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic       rise, fall, start, stop;

	assign rise = scl_in & ~scl_q;
	assign fall = ~scl_in & scl_q;
	assign start = scl_in & scl_q & sda_q & ~sda_in;
	assign stop = scl_in & scl_q & ~sda_q & sda_in;
	assign sda_oe_n_out = ~drive_q;
	assign link.start_seen = start & link.enable;
	assign link.stop_seen = stop & link.enable;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= supervisor_pkg::BS_IDLE;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			done_q <= 1'b0;
			drive_q <= 1'b0;
			link.rx_valid <= 1'b0;
			link.rx_byte <= 8'h00;
		end else begin
			link.rx_valid <= 1'b0;
			if (!link.enable || stop) begin
				st_q <= supervisor_pkg::BS_IDLE;
				drive_q <= 1'b0;
			end else if (start) begin
				st_q <= supervisor_pkg::BS_ADDR;
				bit_q <= 3'h0;
				done_q <= 1'b0;
				drive_q <= 1'b0;
			end else if (rise) begin
				case (st_q)
					supervisor_pkg::BS_ADDR, supervisor_pkg::BS_WRX: begin
						sh_q <= {sh_q[6:0], sda_in};
						bit_q <= bit_q + 3'h1;
						done_q <= (bit_q == 3'h7);
					end
					supervisor_pkg::BS_TX: bit_q <= bit_q + 3'h1;
					supervisor_pkg::BS_ACK_R: if (sda_in) st_q <= supervisor_pkg::BS_IDLE;
					default: ;
				endcase
			end else if (fall) begin
				case (st_q)
					supervisor_pkg::BS_ADDR: if (done_q) begin
						done_q <= 1'b0;
						if (sh_q[7:1] == link.own_addr) begin
							drive_q <= 1'b1;
							st_q <= sh_q[0] ? supervisor_pkg::BS_ACK_R : supervisor_pkg::BS_ACK_A;
						end else begin
							st_q <= supervisor_pkg::BS_IDLE;
						end
					end
					supervisor_pkg::BS_WRX: if (done_q) begin
						done_q <= 1'b0;
						drive_q <= 1'b1;
						link.rx_byte <= sh_q;
						link.rx_valid <= 1'b1;
						st_q <= supervisor_pkg::BS_ACK_W;
					end
					supervisor_pkg::BS_ACK_A, supervisor_pkg::BS_ACK_W: begin
						drive_q <= 1'b0;
						st_q <= supervisor_pkg::BS_WRX;
					end
					supervisor_pkg::BS_ACK_R: begin
						sh_q <= link.tx_byte;
						drive_q <= ~link.tx_byte[7];
						bit_q <= 3'h0;
						st_q <= supervisor_pkg::BS_TX;
					end
					supervisor_pkg::BS_TX: begin
						if (bit_q == 3'h0) begin
							drive_q <= 1'b0;
							st_q <= supervisor_pkg::BS_ACK_R;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							drive_q <= ~sh_q[6];
						end
					end
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/fault_supervisor_share_mode_ctrl.sv */
// Purpose: fault supervision, open-drain fault line and share/standalone mode control
// Assumes: fault inputs are digital comparator results synchronous to ref_clk_in
// Notes: sampling, retry and input-fault timing run from the reference clock
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor_share_mode_ctrl #(
	parameter logic [14:0] SAMPLE_CYCLES = 15'(supervisor_pkg::SAMPLE_CYCLES),
	parameter logic [26:0] RETRY_CYCLES  = 27'(supervisor_pkg::RETRY_CYCLES)
) (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	// monitored conditions
	input  wire logic       input_undervoltage_in,
	input  wire logic       input_overvoltage_in,
	input  wire logic [1:0] output_overvoltage_in,
	input  wire logic [1:0] output_out_of_range_in,
	input  wire logic [1:0] output_overcurrent_in,
	input  wire logic [7:0] temp_a_in,
	input  wire logic [7:0] temp_b_in,
	input  wire logic       sense_open_in,
	// slot address pins
	input  wire logic       slot_addr_low_n_in,
	input  wire logic       slot_addr_high_n_in,
	// serial bus
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n_out,
	// open-drain fault and system reset lines
	output logic            fail_out,
	output logic            fail_oe_n_out,
	output logic            system_reset_out,
	output logic            system_reset_oe_n_out,
	// power train control
	output logic            outputs_on_out,
	output logic            standalone_mode_out,
	output logic            droop_enable_out,
	// nonvolatile mode storage
	input  wire logic       nv_mode_in,
	output logic            nv_write_out,
	output logic            nv_mode_out,
	output logic            soft_reboot_out
);
	serial_link_if link ();

	logic       rst_s1_q, rst_n_q;
	logic       boot_q, reinit;
	logic [14:0] smp_cnt_q;
	logic       tick;
	logic       uv_ov_s_q, oov_s_q, range_s_q, oc_s_q, sense_s_q;
	logic [7:0] tmax_s_q;
	logic [7:0] tmax;
	logic [2:0] in_cnt_q;
	logic       in_down_q, in_down_d;
	logic       ot_q;
	supervisor_pkg::fault_state_type fs_q;
	logic [26:0] retry_q;
	logic       trip;
	logic [7:0] status_q;
	logic [6:0] addr_q;
	logic       mode_q;
	logic [7:0] b1_q, b2_q, b3_q, b4_q;
	logic [2:0] idx_q;
	logic       seq_ok, seq_bad, reg_wr;
	logic [1:0] rep_q;
	logic       rep_mode_q;
	logic       commit_q;

	// reset release through two flops
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// periodic sampling of the monitored supplies
	assign tick = (smp_cnt_q == SAMPLE_CYCLES - 15'h1);
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			smp_cnt_q <= 15'h0;
		end else begin
			smp_cnt_q <= tick ? 15'h0 : smp_cnt_q + 15'h1;
		end
	end

	assign tmax = (temp_a_in > temp_b_in) ? temp_a_in : temp_b_in;
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			uv_ov_s_q <= 1'b0;
			oov_s_q <= 1'b0;
			range_s_q <= 1'b0;
			oc_s_q <= 1'b0;
			sense_s_q <= 1'b0;
			tmax_s_q <= 8'h00;
		end else if (tick) begin
			uv_ov_s_q <= input_undervoltage_in | input_overvoltage_in;
			oov_s_q <= |output_overvoltage_in;
			range_s_q <= |output_out_of_range_in;
			oc_s_q <= |output_overcurrent_in;
			sense_s_q <= sense_open_in;
			tmax_s_q <= tmax;
		end
	end

	// input voltage guard: five bad samples span the 1ms window
	always_comb begin
		in_down_d = in_down_q;
		if (!in_down_q && uv_ov_s_q && in_cnt_q == supervisor_pkg::IN_FAULT_SAMPLES - 3'h1)
			in_down_d = 1'b1;
		else if (in_down_q && !uv_ov_s_q)
			in_down_d = 1'b0;
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			in_cnt_q <= 3'h0;
			in_down_q <= 1'b0;
		end else if (tick) begin
			in_down_q <= in_down_d;
			if (!uv_ov_s_q || in_down_q)
				in_cnt_q <= 3'h0;
			else if (in_cnt_q != supervisor_pkg::IN_FAULT_SAMPLES)
				in_cnt_q <= in_cnt_q + 3'h1;
		end
	end

	// recovery from an input fault or a commit behaves as a fresh power up
	assign reinit = !boot_q || (tick && in_down_q && !in_down_d) || commit_q;

	// overtemperature with hysteresis
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ot_q <= 1'b0;
		end else if (tmax_s_q >= supervisor_pkg::OT_ENTER_C) begin
			ot_q <= 1'b1;
		end else if (tmax_s_q <= supervisor_pkg::OT_LEAVE_C) begin
			ot_q <= 1'b0;
		end
	end

	// overvoltage and overcurrent shutdown with timed restart attempts
	assign trip = oov_s_q | oc_s_q;
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fs_q <= supervisor_pkg::FS_RUN;
			retry_q <= 27'h0;
		end else begin
			case (fs_q)
				supervisor_pkg::FS_RUN: begin
					retry_q <= 27'h0;
					if (trip)
						fs_q <= supervisor_pkg::FS_TRIP;
				end
				supervisor_pkg::FS_TRIP: begin
					if (retry_q == RETRY_CYCLES - 27'h1) begin
						retry_q <= 27'h0;
						if (!trip)
							fs_q <= supervisor_pkg::FS_RUN;
					end else begin
						retry_q <= retry_q + 27'h1;
					end
				end
				default: fs_q <= supervisor_pkg::FS_RUN;
			endcase
		end
	end

	// power train and open-drain lines
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			outputs_on_out <= 1'b0;
			fail_oe_n_out <= 1'b0;
			system_reset_oe_n_out <= 1'b0;
		end else begin
			outputs_on_out <= boot_q && !in_down_q && !ot_q && !sense_s_q && !trip && !commit_q
				&& fs_q == supervisor_pkg::FS_RUN;
			fail_oe_n_out <= !(oov_s_q || range_s_q || oc_s_q || fs_q == supervisor_pkg::FS_TRIP
				|| !boot_q);
			system_reset_oe_n_out <= !(!boot_q || in_down_q || commit_q);
		end
	end
	assign fail_out = 1'b0;
	assign system_reset_out = 1'b0;
	assign sda_out = 1'b0;

	// address and mode caught after reset release and on every reinit
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			boot_q <= 1'b0;
			addr_q <= 7'h00;
			mode_q <= supervisor_pkg::MODE_SHARE;
		end else begin
			boot_q <= 1'b1;
			if (reinit) begin
				addr_q <= {supervisor_pkg::ADDR_PREFIX, ~slot_addr_high_n_in, ~slot_addr_low_n_in};
				mode_q <= commit_q ? rep_mode_q : nv_mode_in;
			end else if (seq_ok) begin
				mode_q <= (b3_q == supervisor_pkg::CMD3_STANDALONE);
			end
		end
	end
	assign standalone_mode_out = mode_q;
	assign droop_enable_out = ~mode_q;

	// write transaction capture
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			idx_q <= 3'h0;
			b1_q <= 8'h00;
			b2_q <= 8'h00;
			b3_q <= 8'h00;
			b4_q <= 8'h00;
		end else if (reinit || link.start_seen) begin
			idx_q <= 3'h0;
		end else if (link.rx_valid) begin
			if (idx_q != 3'h7)
				idx_q <= idx_q + 3'h1;
			case (idx_q)
				3'h0: b1_q <= link.rx_byte;
				3'h1: b2_q <= link.rx_byte;
				3'h2: b3_q <= link.rx_byte;
				3'h3: b4_q <= link.rx_byte;
				default: ;
			endcase
		end
	end

	// a mode sequence is checked at the stop condition
	always_comb begin
		seq_ok = 1'b0;
		seq_bad = 1'b0;
		reg_wr = 1'b0;
		if (link.stop_seen && !reinit) begin
			if (b1_q == supervisor_pkg::CMD_BYTE1 && idx_q != 3'h0) begin
				if (idx_q == supervisor_pkg::CMD_LEN && b2_q == supervisor_pkg::CMD_BYTE2
					&& (b3_q == supervisor_pkg::CMD3_STANDALONE || b3_q == supervisor_pkg::CMD3_SHARE)
					&& 8'(b1_q + b2_q + b3_q + b4_q) == 8'h00)
					seq_ok = 1'b1;
				else
					seq_bad = 1'b1;
			end else if (b1_q == supervisor_pkg::STATUS_OFFSET && idx_q == supervisor_pkg::REG_WR_LEN) begin
				reg_wr = 1'b1;
			end
		end
	end

	// consecutive repetition count and commit
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rep_q <= 2'h0;
			rep_mode_q <= supervisor_pkg::MODE_SHARE;
			commit_q <= 1'b0;
		end else begin
			commit_q <= 1'b0;
			if (reinit) begin
				rep_q <= 2'h0;
			end else if (seq_bad) begin
				rep_q <= 2'h0;
			end else if (seq_ok) begin
				rep_mode_q <= (b3_q == supervisor_pkg::CMD3_STANDALONE);
				if (rep_q != 2'h0 && rep_mode_q == (b3_q == supervisor_pkg::CMD3_STANDALONE)) begin
					if (rep_q == supervisor_pkg::COMMIT_REPEATS - 2'h1) begin
						rep_q <= 2'h0;
						commit_q <= 1'b1;
					end else begin
						rep_q <= rep_q + 2'h1;
					end
				end else begin
					rep_q <= 2'h1;
				end
			end
		end
	end
	assign nv_write_out = commit_q;
	assign soft_reboot_out = commit_q;
	assign nv_mode_out = rep_mode_q;

	// status register: host writes, warning bit cleared by hardware near shutdown
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= supervisor_pkg::STATUS_RESET;
		end else if (reinit) begin
			status_q <= supervisor_pkg::STATUS_RESET;
		end else begin
			if (reg_wr)
				status_q <= b2_q;
			if (tmax_s_q >= supervisor_pkg::WARN_C)
				status_q[supervisor_pkg::WARN_BIT] <= 1'b0;
		end
	end

	assign link.own_addr = addr_q;
	assign link.enable = boot_q && !in_down_q && !commit_q;
	assign link.tx_byte = status_q;

	serial_bus_engine u_engine (
		.clk_in       (ref_clk_in),
		.rst_n_in     (rst_n_q),
		.scl_in       (scl_in),
		.sda_in       (sda_in),
		.sda_oe_n_out (sda_oe_n_out),
		.link         (link)
	);

	input_down_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		in_down_q |-> !link.enable ##1 !outputs_on_out) else $error("outputs on during input fault");
	fail_ov_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		$past(oov_s_q) |-> !fail_oe_n_out) else $error("fault line released during overvoltage");
	oc_shut_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		oc_s_q |=> !outputs_on_out && fs_q == supervisor_pkg::FS_TRIP) else $error("overcurrent not shut");
	retry_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		fs_q == supervisor_pkg::FS_TRIP && retry_q != RETRY_CYCLES - 27'h1 |=> fs_q == supervisor_pkg::FS_TRIP
		&& !outputs_on_out) else $error("restart before retry period");
	ot_enter_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		tmax_s_q >= 8'h5f |=> ot_q ##1 !outputs_on_out) else $error("overtemperature missed");
	ot_leave_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		$fell(ot_q) |-> $past(tmax_s_q) <= 8'h4b) else $error("overtemperature left early");
	warn_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		tmax_s_q >= 8'h55 && !reinit |=> !status_q[5]) else $error("warning bit not cleared");
	sense_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		$past(sense_s_q) |-> !outputs_on_out) else $error("outputs on with open sense");
	commit_third_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		commit_q |-> $past(rep_q) == 2'h2 && $past(seq_ok)) else $error("commit without three repeats");
	commit_mode_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		commit_q |=> mode_q == $past(rep_mode_q) && !outputs_on_out) else $error("commit reboot wrong");
	bad_seq_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
		seq_bad |=> rep_q == 2'h0 && !commit_q) else $error("bad sequence kept count");
endmodule
`default_nettype wire

/* File: testbench/host_model.sv */
// Purpose: serial bus host that sends mode commands and status accesses
// Assumes: sda is resolved outside with a pull-up, scl is driven here only
// Notes: all line changes happen on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model #(
	parameter int QTR = 313
) (
	// clock and bus lines
	input  wire logic       clk_in,
	input  wire logic       sda_in,
	// slot address bits of the addressed device, high bit first
	input  wire logic [1:0] slot_in,
	// driven bus lines
	output var logic        scl_out,
	output var logic        sda_drv_out
);
	initial begin
		scl_out = 1'b1;
		sda_drv_out = 1'b1;
	end
	task automatic dly();
		repeat (QTR) @(negedge clk_in);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_drv_out = b;
		dly();
		scl_out = 1'b1;
		dly();
		r = sda_in;
		dly();
		scl_out = 1'b0;
		dly();
	endtask
	task automatic start();
		sda_drv_out = 1'b1;
		scl_out = 1'b1;
		dly();
		sda_drv_out = 1'b0;
		dly();
		scl_out = 1'b0;
		dly();
	endtask
	task automatic stop();
		sda_drv_out = 1'b0;
		dly();
		scl_out = 1'b1;
		dly();
		sda_drv_out = 1'b1;
		dly();
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(1'b1, r);
	endtask
	// a wrong checksum is sent only when bad is set; commits stay few
	task automatic send_mode(input logic [7:0] b3, input logic bad, output logic ok);
		logic a;
		logic [7:0] ck;
		ck = 8'h00 - supervisor_pkg::CMD_BYTE1 - supervisor_pkg::CMD_BYTE2 - b3;
		ck = ck ^ {7'h00, bad};
		start();
		wr({supervisor_pkg::ADDR_PREFIX, slot_in, 1'b0}, ok);
		wr(supervisor_pkg::CMD_BYTE1, a);
		wr(supervisor_pkg::CMD_BYTE2, a);
		wr(b3, a);
		wr(ck, a);
		stop();
	endtask
	task automatic reg_wr(input logic [7:0] d);
		logic a;
		start();
		wr({supervisor_pkg::ADDR_PREFIX, slot_in, 1'b0}, a);
		wr(supervisor_pkg::STATUS_OFFSET, a);
		wr(d, a);
		stop();
	endtask
	task automatic reg_rd(output logic [7:0] d);
		logic a;
		start();
		wr({supervisor_pkg::ADDR_PREFIX, slot_in, 1'b1}, a);
		rd(d);
		stop();
	endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for fault supervision and share-mode control
// Assumes: short sample and retry counts, fast serial bus
// Notes: nv storage is modelled by latching nv_mode_out on each write pulse
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int SMP = 20;
	localparam int RTY = 200;
	logic       ref_clk, rst_n, uv, ov, sense, nv_mode, ok;
	logic [1:0] oov, oor, oc, slot_n;
	logic [7:0] ta, tb_t, d;
	logic       scl, h_sda, sda_oe_n, fail_oe_n, sr_oe_n, sda_o, fail_o, sr_o, on, sa, droop, nwr, nval, rb;
	int         fail_count, n_compared, nwr_cnt, rb_cnt;
	// open-drain lines with their backplane pull-ups
	wire logic  sda_w = h_sda & (sda_oe_n | sda_o);
	wire logic  fail_n = fail_oe_n | fail_o;
	wire logic  sr_n = sr_oe_n | sr_o;
	host_model #(.QTR(8)) host (.clk_in(ref_clk), .sda_in(sda_w), .slot_in(~slot_n), .scl_out(scl),
		.sda_drv_out(h_sda));
	fault_supervisor_share_mode_ctrl #(.SAMPLE_CYCLES(15'(SMP)), .RETRY_CYCLES(27'(RTY))) dut (
		.ref_clk_in(ref_clk), .rst_n_in(rst_n), .input_undervoltage_in(uv), .input_overvoltage_in(ov),
		.output_overvoltage_in(oov), .output_out_of_range_in(oor), .output_overcurrent_in(oc),
		.temp_a_in(ta), .temp_b_in(tb_t), .sense_open_in(sense), .slot_addr_low_n_in(slot_n[0]),
		.slot_addr_high_n_in(slot_n[1]), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
		.fail_out(fail_o), .fail_oe_n_out(fail_oe_n), .system_reset_out(sr_o), .system_reset_oe_n_out(sr_oe_n),
		.outputs_on_out(on), .standalone_mode_out(sa), .droop_enable_out(droop), .nv_mode_in(nv_mode),
		.nv_write_out(nwr), .nv_mode_out(nval), .soft_reboot_out(rb));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// storage model: keeps what the design asks to store
	always @(negedge ref_clk) begin
		if (nwr === 1'b1) begin
			nwr_cnt++;
			nv_mode <= nval;
		end
		if (rb === 1'b1) rb_cnt++;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n * SMP + 4) @(negedge ref_clk);
	endtask
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic test_boot();
		settle(2);
		chk(on, 1, "outputs after boot");
		chk(sa, 0, "share mode at boot");
		chk(droop, 1, "droop in share mode");
		chk(fail_n, 1, "fault line idle");
		$display("test boot done");
	endtask
	task automatic test_oc();
		oc = 2'b10;
		settle(2);
		chk(on, 0, "overcurrent shutdown");
		chk(fail_n, 0, "overcurrent fault line");
		repeat (RTY + 2 * SMP) @(negedge ref_clk);
		chk(on, 0, "held overcurrent stays off");
		oc = 2'b00;
		repeat (RTY + 3 * SMP) @(negedge ref_clk);
		chk(on, 1, "restart after overcurrent");
		$display("test overcurrent done");
	endtask
	task automatic test_temp();
		tb_t = 8'h5e;
		settle(2);
		chk(on, 1, "94C keeps outputs on");
		tb_t = 8'h5f;
		settle(2);
		chk(on, 0, "95C shutdown");
		tb_t = 8'h50;
		settle(3);
		chk(on, 0, "80C still off");
		tb_t = 8'h4b;
		settle(2);
		chk(on, 1, "75C recovery");
		tb_t = 8'h19;
		$display("test temperature done");
	endtask
	task automatic test_status();
		host.reg_wr(8'h20);
		host.reg_rd(d);
		chk(d, 8'h20, "status write readback");
		ta = 8'h55;
		settle(2);
		host.reg_rd(d);
		chk(d, 8'h00, "warning bit cleared at 85C");
		ta = 8'h19;
		$display("test status done");
	endtask
	task automatic test_mode();
		host.send_mode(supervisor_pkg::CMD3_SHARE, 1'b0, ok);
		chk(ok, 1, "address acknowledged");
		chk(sa, 0, "share command");
		host.send_mode(supervisor_pkg::CMD3_STANDALONE, 1'b0, ok);
		chk(sa, 1, "standalone command");
		chk(droop, 0, "no droop standalone");
		host.send_mode(supervisor_pkg::CMD3_STANDALONE, 1'b0, ok);
		host.send_mode(supervisor_pkg::CMD3_STANDALONE, 1'b1, ok);
		chk(sa, 1, "bad checksum ignored");
		host.send_mode(supervisor_pkg::CMD3_STANDALONE, 1'b0, ok);
		host.send_mode(supervisor_pkg::CMD3_STANDALONE, 1'b0, ok);
		chk(nwr_cnt, 0, "no commit after reset count");
		host.send_mode(supervisor_pkg::CMD3_STANDALONE, 1'b0, ok);
		chk(nwr_cnt, 1, "commit on third");
		chk(nv_mode, 1, "stored mode");
		chk(rb_cnt, 1, "one soft reboot");
		settle(2);
		chk(sa, 1, "committed mode after reboot");
		chk(on, 1, "outputs back after reboot");
		$display("test mode done");
	endtask
	task automatic test_infault();
		host.send_mode(supervisor_pkg::CMD3_SHARE, 1'b0, ok);
		chk(sa, 0, "temporary share");
		uv = 1'b1;
		settle(3);
		chk(on, 1, "short input fault ignored");
		settle(3);
		chk(on, 0, "input fault shutdown");
		chk(sr_n, 0, "reset line pulled");
		uv = 1'b0;
		settle(3);
		chk(sa, 1, "uncommitted mode lost");
		chk(on, 1, "outputs after input recovery");
		ov = 1'b1;
		settle(6);
		chk(on, 0, "input overvoltage shutdown");
		ov = 1'b0;
		settle(3);
		$display("test input fault done");
	endtask
	task automatic test_rail();
		oov = 2'b01;
		settle(2);
		chk(fail_n, 0, "output overvoltage fault line");
		chk(on, 0, "output overvoltage shutdown");
		oov = 2'b00;
		repeat (RTY + 3 * SMP) @(negedge ref_clk);
		chk(on, 1, "overvoltage retry restart");
		oor = 2'b10;
		settle(2);
		chk(fail_n, 0, "out of range fault line");
		oor = 2'b00;
		sense = 1'b1;
		settle(2);
		chk(on, 0, "open sense keeps off");
		sense = 1'b0;
		settle(2);
		chk(on, 1, "sense restored");
		$display("test rails done");
	endtask
	task automatic test_repower();
		host.send_mode(supervisor_pkg::CMD3_SHARE, 1'b0, ok);
		chk(sa, 0, "temporary share before power cycle");
		slot_n = 2'h1;
		rst_n = 1'b0;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		settle(2);
		chk(sa, 1, "stored mode after power cycle");
		chk(on, 1, "outputs after power cycle");
		host.send_mode(supervisor_pkg::CMD3_SHARE, 1'b0, ok);
		chk(ok, 1, "new slot address acknowledged");
		chk(sa, 0, "share command at new slot address");
		$display("test power cycle done");
	endtask
	initial begin
		{uv, ov, sense, nv_mode, rst_n} = 5'h00;
		{oov, oor, oc} = 6'h00;
		slot_n = 2'h3;
		ta = 8'h19;
		tb_t = 8'h19;
		fail_count = 0;
		n_compared = 0;
		nwr_cnt = 0;
		rb_cnt = 0;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		test_boot();
		test_oc();
		test_temp();
		test_status();
		test_mode();
		test_infault();
		test_rail();
		test_repower();
		wrap_up();
	end
	initial begin
		repeat (80000) @(posedge ref_clk);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
`default_nettype wire
